// *** logic/param_store.sv ***
`timescale 1ns/1ps
module param_store (
  input  wire logic       clk,
  input  wire logic       we,
  input  wire logic [5:0] waddr,
  input  wire logic [7:0] wdata,
  input  wire logic       re,
  input  wire logic [5:0] raddr,
  output logic      [7:0] rdata
);

  logic [7:0] mem [0:63];

  // Write port
  always_ff @(posedge clk)
  begin
    if (we)
      mem[waddr] <= wdata;
  end

  // Registered read, zero when not enabled
  always_ff @(posedge clk)
  begin
    if (re)
      rdata <= mem[raddr];
    else
      rdata <= 8'h00;
  end

endmodule : param_store

// *** logic/pin_sync.sv ***
`timescale 1ns/1ps
module pin_sync (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pin_in,
  output logic      level
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // Three stages; first stage feeds only the second
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
      s3_reg <= 1'b1;
    end
    else
    begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Level moves only once stages two and three agree
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      level <= 1'b1;
    else if (s2_reg == s3_reg)
      level <= s2_reg;
  end

endmodule : pin_sync

// *** logic/recovery_pin_param_restore.sv ***
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/1ps
// Functional notes
// RULE1: Only the recovery pin path restores parameters
// RULE2: Ignore pin for thirty seconds after power-on
// RULE3: Five second hold qualifies light recovery
// RULE4: Light recovery and reset on pin release
// RULE5: Twenty second hold forces immediate deep recovery
// RULE6: Internal pull-up keeps idle pin high
// RULE7: Light restores password, PWM modes, outputs
// RULE8: Deep adds light defaults plus 9600 baud
// RULE9: Deep restores name prefix plus address chars
// RULE10: Deep sets data delay setting to zero
// RULE11: Deep sets all PWM frequencies to default
// RULE12: Deep sets advertising cycle setting to two
// RULE13: Deep sets 30 ms interval, 0 dBm
// RULE14: Deep restores default product identifier
// RULE15: Deep clears I/O configuration byte
// RULE16: Deep clears custom advertising length and data
// RULE17: Deep sets enable-pin mode to level
// RULE18: Board must not hold pin low at power-on
// RULE19: Release under 5 s does nothing; timer restarts
// RULE20: Pin synchronised; hold counted by prescaled tick
module recovery_pin_param_restore #(
  parameter int unsigned TICK_CYCLES = recovery_pkg::TICK_CYCLES,
  parameter logic [31:0] NAME_PREFIX = 32'h4445562d, // Arbitrary name prefix
  parameter logic [15:0] PRODUCT_ID  = 16'h5a3c      // Arbitrary identifier value
) (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        RESTORE_N,
  input  wire logic        CMD_RESET,
  input  wire logic        REMOTE_RESET,
  input  wire logic [47:0] HW_ADDR,
  input  wire logic [5:0]  ADDR,
  input  wire logic [7:0]  WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [7:0]  RDATA,
  output logic             PULLUP_EN,
  output logic             SYS_RESET_REQ,
  output logic             LIGHT_DONE,
  output logic             DEEP_DONE,
  output logic             LOCKOUT_DONE,
  output logic             HOLD_ACTIVE,
  output logic             LIGHT_ARMED,
  output logic             RESTORE_BUSY
);

  recovery_pkg::state_t state_reg;
  recovery_pkg::state_t state_next;
  logic        pin_lvl;
  logic [17:0] tick_cnt_reg;
  logic        tick_reg;
  logic [14:0] lock_cnt_reg;
  logic [14:0] hold_cnt_reg;
  logic        deep_reg;
  logic [5:0]  idx_reg;
  logic [5:0]  last_idx;
  logic        apply_end;
  logic        host_we;
  logic        mem_we;
  logic [5:0]  mem_waddr;
  logic [7:0]  mem_wdata;
  logic        mem_re;

  // Hex digit to ASCII character
  function automatic logic [7:0] hex_char(input logic [3:0] nib);
    logic [7:0] wide;
    wide = {4'h0, nib};
    if (nib < 4'ha)
      hex_char = 8'h30 + wide;
    else
      hex_char = 8'h37 + wide;
  endfunction : hex_char

  // Default byte for each store index
  function automatic logic [7:0] param_default(
    input logic [5:0]  idx,
    input logic [31:0] mac_lo,
    input logic [31:0] prefix,
    input logic [15:0] pid
  );
    logic [7:0] val;
    logic [5:0] off;
    val = 8'h00;
    off = 6'h00;
    if (idx < recovery_pkg::PWM_MODE_BASE)
      val = recovery_pkg::PASSWORD_DEFAULT;                 // [RULE7]
    else if (idx < recovery_pkg::IO_OUT_IDX)
      val = recovery_pkg::PWM_MODE_DEFAULT;                 // [RULE7]
    else if (idx == recovery_pkg::IO_OUT_IDX)
      val = recovery_pkg::IO_OUT_DEFAULT;                   // [RULE7]
    else if (idx == recovery_pkg::BAUD_IDX)
      val = recovery_pkg::BAUD_9600_CODE;                   // [RULE8]
    else if (idx == recovery_pkg::DELAY_IDX)
      val = recovery_pkg::DELAY_DEFAULT;                    // [RULE10]
    else if (idx < recovery_pkg::ADV_CYCLE_IDX)
    begin
      off = idx - recovery_pkg::PWM_FREQ_BASE;
      if (off[0])
        val = recovery_pkg::PWM_FREQ_DEFAULT[15:8];         // [RULE11]
      else
        val = recovery_pkg::PWM_FREQ_DEFAULT[7:0];          // [RULE11]
    end
    else if (idx == recovery_pkg::ADV_CYCLE_IDX)
      val = recovery_pkg::ADV_CYCLE_DEFAULT;                // [RULE12]
    else if (idx == recovery_pkg::CONN_IDX)
      val = recovery_pkg::CONN_INTERVAL_MS;                 // [RULE13]
    else if (idx == recovery_pkg::TX_POWER_IDX)
      val = recovery_pkg::TX_POWER_0DBM;                    // [RULE13]
    else if (idx == recovery_pkg::PID_BASE)
      val = pid[7:0];                                       // [RULE14]
    else if (idx < recovery_pkg::IO_CFG_IDX)
      val = pid[15:8];                                      // [RULE14]
    else if (idx == recovery_pkg::IO_CFG_IDX)
      val = recovery_pkg::IO_CFG_DEFAULT;                   // [RULE15]
    else if (idx == recovery_pkg::EN_MODE_IDX)
      val = recovery_pkg::EN_MODE_DEFAULT;                  // [RULE17]
    else if (idx == recovery_pkg::ADV_LEN_IDX)
      val = recovery_pkg::ADV_LEN_DEFAULT;                  // [RULE16]
    else if (idx < recovery_pkg::NAME_BASE)
      val = recovery_pkg::ADV_DATA_DEFAULT;                 // [RULE16]
    else if (idx < recovery_pkg::NAME_HEX_BASE)
    begin
      off = idx - recovery_pkg::NAME_BASE;
      val = 8'(prefix >> (5'd24 - {off[1:0], 3'b000}));     // [RULE9]
    end
    else
    begin
      off = idx - recovery_pkg::NAME_HEX_BASE;
      val = hex_char(4'(mac_lo >> (5'd28 - {off[2:0], 2'b00}))); // [RULE9]
    end
    param_default = val;
  endfunction : param_default

  // Recovery pin synchroniser
  pin_sync u_pin_sync (
    .clk    (CLK),
    .rst    (RST),
    .pin_in (RESTORE_N),
    .level  (pin_lvl)
  );                                                        // [RULE20]

  // Millisecond tick prescaler
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      tick_cnt_reg <= 18'h00000;
      tick_reg     <= 1'b0;
    end
    else if (tick_cnt_reg == 18'(TICK_CYCLES - 1))
    begin
      tick_cnt_reg <= 18'h00000;
      tick_reg     <= 1'b1;                                 // [RULE20]
    end
    else
    begin
      tick_cnt_reg <= tick_cnt_reg + 18'h00001;
      tick_reg     <= 1'b0;
    end
  end

  // Power-on lockout counter
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      lock_cnt_reg <= 15'h0000;
    else if (tick_reg && lock_cnt_reg != recovery_pkg::LOCKOUT_TICKS)
      lock_cnt_reg <= lock_cnt_reg + 15'h0001;              // [RULE2]
  end

  // Hold timer, restarted whenever a measurement begins
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      hold_cnt_reg <= 15'h0000;
    else if (state_reg == recovery_pkg::ST_IDLE)
      hold_cnt_reg <= 15'h0000;                             // [RULE19]
    else if (tick_reg && (state_reg == recovery_pkg::ST_HOLD ||
                          state_reg == recovery_pkg::ST_ARMED))
      hold_cnt_reg <= hold_cnt_reg + 15'h0001;              // [RULE20]
  end

  assign last_idx  = deep_reg ? recovery_pkg::DEEP_LAST : recovery_pkg::LIGHT_LAST;
  assign apply_end = (state_reg == recovery_pkg::ST_APPLY) && (idx_reg == last_idx);

  // Next state of the recovery sequencer
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      recovery_pkg::ST_LOCK:
        if (lock_cnt_reg == recovery_pkg::LOCKOUT_TICKS)
          state_next = recovery_pkg::ST_IDLE;               // [RULE2]
      recovery_pkg::ST_IDLE:
        if (!pin_lvl)
          state_next = recovery_pkg::ST_HOLD;
      recovery_pkg::ST_HOLD:
        if (pin_lvl)
          state_next = recovery_pkg::ST_IDLE;               // [RULE19]
        else if (hold_cnt_reg >= recovery_pkg::LIGHT_TICKS)
          state_next = recovery_pkg::ST_ARMED;              // [RULE3]
      recovery_pkg::ST_ARMED:
        if (hold_cnt_reg >= recovery_pkg::DEEP_TICKS)
          state_next = recovery_pkg::ST_APPLY;              // [RULE5]
        else if (pin_lvl)
          state_next = recovery_pkg::ST_APPLY;              // [RULE4]
      recovery_pkg::ST_APPLY:
        if (apply_end)
          state_next = recovery_pkg::ST_RESET;
      recovery_pkg::ST_RESET:
        if (pin_lvl)
          state_next = recovery_pkg::ST_IDLE;
        else
          state_next = recovery_pkg::ST_WAIT_HIGH;
      recovery_pkg::ST_WAIT_HIGH:
        if (pin_lvl)
          state_next = recovery_pkg::ST_IDLE;
      default:
        state_next = recovery_pkg::ST_LOCK;
    endcase
  end

  // State register
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      state_reg <= recovery_pkg::ST_LOCK;
    else
      state_reg <= state_next;
  end

  // Recovery depth, latched as the walk starts
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      deep_reg <= 1'b0;
    else if (state_reg == recovery_pkg::ST_ARMED)
      deep_reg <= (hold_cnt_reg >= recovery_pkg::DEEP_TICKS); // [RULE5]
  end

  // Store index walk
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      idx_reg <= 6'h00;
    else if (state_reg == recovery_pkg::ST_APPLY)
      idx_reg <= idx_reg + 6'h01;
    else
      idx_reg <= 6'h00;
  end

  // Store access: recovery walk owns the write port while busy
  assign host_we   = WR && (ADDR < recovery_pkg::PARAM_COUNT) &&
                     (state_reg != recovery_pkg::ST_APPLY);
  assign mem_we    = (state_reg == recovery_pkg::ST_APPLY) || host_we; // [RULE1]
  assign mem_waddr = (state_reg == recovery_pkg::ST_APPLY) ? idx_reg : ADDR;
  assign mem_wdata = (state_reg == recovery_pkg::ST_APPLY) ?
                     param_default(idx_reg, HW_ADDR[31:0], NAME_PREFIX, PRODUCT_ID) : WDATA;
  assign mem_re    = RD && (ADDR < recovery_pkg::PARAM_COUNT);

  param_store u_param_store (
    .clk   (CLK),
    .we    (mem_we),
    .waddr (mem_waddr),
    .wdata (mem_wdata),
    .re    (mem_re),
    .raddr (ADDR),
    .rdata (RDATA)
  );

  // Reset request and completion pulses
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      SYS_RESET_REQ <= 1'b0;
      LIGHT_DONE    <= 1'b0;
      DEEP_DONE     <= 1'b0;
    end
    else
    begin
      SYS_RESET_REQ <= apply_end || CMD_RESET || REMOTE_RESET; // [RULE1] [RULE4]
      LIGHT_DONE    <= apply_end && !deep_reg;
      DEEP_DONE     <= apply_end && deep_reg;
    end
  end

  // Status levels taken from the next state
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      LOCKOUT_DONE <= 1'b0;
      HOLD_ACTIVE  <= 1'b0;
      LIGHT_ARMED  <= 1'b0;
      RESTORE_BUSY <= 1'b0;
    end
    else
    begin
      LOCKOUT_DONE <= (state_next != recovery_pkg::ST_LOCK);
      HOLD_ACTIVE  <= (state_next == recovery_pkg::ST_HOLD) ||
                      (state_next == recovery_pkg::ST_ARMED);
      LIGHT_ARMED  <= (state_next == recovery_pkg::ST_ARMED);
      RESTORE_BUSY <= (state_next == recovery_pkg::ST_APPLY);
    end
  end

  // Pull-up enable on the recovery pin
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      PULLUP_EN <= 1'b1;
    else
      PULLUP_EN <= 1'b1;                                    // [RULE6]
  end

  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  chk_lockout_ignore: assert property ( // [RULE2]
    (lock_cnt_reg != recovery_pkg::LOCKOUT_TICKS) |-> (state_reg == recovery_pkg::ST_LOCK)
  ) else $error("Pin measured before lockout ended");

  chk_light_qualify: assert property ( // [RULE3]
    (state_reg == recovery_pkg::ST_HOLD && !pin_lvl &&
     hold_cnt_reg >= recovery_pkg::LIGHT_TICKS) |=> (state_reg == recovery_pkg::ST_ARMED)
  ) else $error("Light hold not qualified");

  chk_light_release: assert property ( // [RULE4]
    (state_reg == recovery_pkg::ST_ARMED && pin_lvl &&
     hold_cnt_reg < recovery_pkg::DEEP_TICKS)
    |=> (state_reg == recovery_pkg::ST_APPLY && !deep_reg)
        ##10 (state_reg == recovery_pkg::ST_APPLY) ##1 SYS_RESET_REQ && LIGHT_DONE
  ) else $error("Light recovery not run on release");

  chk_deep_at_once: assert property ( // [RULE5]
    (state_reg == recovery_pkg::ST_ARMED && hold_cnt_reg >= recovery_pkg::DEEP_TICKS)
    |=> (state_reg == recovery_pkg::ST_APPLY && deep_reg) ##57 DEEP_DONE
  ) else $error("Deep recovery not immediate");

  chk_early_release: assert property ( // [RULE19]
    (state_reg == recovery_pkg::ST_HOLD && pin_lvl)
    |=> (state_reg == recovery_pkg::ST_IDLE) ##1 (hold_cnt_reg == 15'h0000)
  ) else $error("Early release not ignored");

  chk_pullup_held: assert property ( // [RULE6]
    PULLUP_EN && $stable(PULLUP_EN)
  ) else $error("Pull-up dropped");

  chk_light_scope: assert property ( // [RULE7]
    (state_reg == recovery_pkg::ST_APPLY && !deep_reg)
    |-> (idx_reg <= recovery_pkg::LIGHT_LAST)
  ) else $error("Light recovery wrote beyond its set");

  chk_default_value: assert property ( // [RULE8]
    (state_reg == recovery_pkg::ST_APPLY)
    |-> mem_we && (mem_waddr == idx_reg) &&
        (mem_wdata == param_default(idx_reg, HW_ADDR[31:0], NAME_PREFIX, PRODUCT_ID))
  ) else $error("Recovery wrote wrong default");

  chk_cmd_no_restore: assert property ( // [RULE1]
    ((CMD_RESET || REMOTE_RESET) && state_reg == recovery_pkg::ST_IDLE)
    |=> SYS_RESET_REQ && !RESTORE_BUSY && !LIGHT_DONE && !DEEP_DONE
  ) else $error("Command reset restored parameters");

  chk_tick_period: assert property ( // [RULE20]
    (tick_cnt_reg == 18'(TICK_CYCLES - 1)) |=> tick_reg && (tick_cnt_reg == 18'h00000)
  ) else $error("Tick not at prescaler wrap");

endmodule : recovery_pin_param_restore

// *** logic/recovery_pkg.sv ***
package recovery_pkg;

  // Clock and time base
  localparam int unsigned CLK_PERIOD_NS  = 4;
  localparam int unsigned TICK_PERIOD_NS = 1000000;
  localparam int unsigned TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned TICK_MS        = 1;

  // Hold and lockout times, in milliseconds and in ticks
  localparam int unsigned LOCKOUT_MS     = 30000;
  localparam int unsigned LIGHT_HOLD_MS  = 5000;
  localparam int unsigned DEEP_HOLD_MS   = 20000;
  localparam logic [14:0] LOCKOUT_TICKS  = 15'(LOCKOUT_MS / TICK_MS);
  localparam logic [14:0] LIGHT_TICKS    = 15'(LIGHT_HOLD_MS / TICK_MS);
  localparam logic [14:0] DEEP_TICKS     = 15'(DEEP_HOLD_MS / TICK_MS);

  // Parameter store layout, one byte per index
  localparam int unsigned ADDR_W         = 6;
  localparam logic [5:0]  PASSWORD_BASE  = 6'h00;
  localparam logic [5:0]  PWM_MODE_BASE  = 6'h06;
  localparam logic [5:0]  IO_OUT_IDX     = 6'h0a;
  localparam logic [5:0]  LIGHT_LAST     = 6'h0a;
  localparam logic [5:0]  BAUD_IDX       = 6'h0b;
  localparam logic [5:0]  DELAY_IDX      = 6'h0c;
  localparam logic [5:0]  PWM_FREQ_BASE  = 6'h0d;
  localparam logic [5:0]  ADV_CYCLE_IDX  = 6'h15;
  localparam logic [5:0]  CONN_IDX       = 6'h16;
  localparam logic [5:0]  TX_POWER_IDX   = 6'h17;
  localparam logic [5:0]  PID_BASE       = 6'h18;
  localparam logic [5:0]  IO_CFG_IDX     = 6'h1a;
  localparam logic [5:0]  EN_MODE_IDX    = 6'h1b;
  localparam logic [5:0]  ADV_LEN_IDX    = 6'h1c;
  localparam logic [5:0]  ADV_DATA_BASE  = 6'h1d;
  localparam logic [5:0]  NAME_BASE      = 6'h2d;
  localparam logic [5:0]  NAME_HEX_BASE  = 6'h31;
  localparam logic [5:0]  DEEP_LAST      = 6'h38;
  localparam logic [5:0]  PARAM_COUNT    = 6'h39;

  // Default values written by a recovery
  localparam logic [7:0]  PASSWORD_DEFAULT = 8'h00;
  localparam logic [7:0]  PWM_MODE_DEFAULT = 8'h01;
  localparam logic [7:0]  IO_OUT_DEFAULT   = 8'h00;
  localparam logic [7:0]  BAUD_9600_CODE   = 8'h00;
  localparam logic [7:0]  DELAY_DEFAULT    = 8'h00;
  localparam logic [15:0] PWM_FREQ_DEFAULT = 16'h8235;
  localparam logic [7:0]  ADV_CYCLE_DEFAULT = 8'h02;
  localparam logic [7:0]  CONN_INTERVAL_MS = 8'h1e;
  localparam logic [7:0]  TX_POWER_0DBM    = 8'h00;
  localparam logic [7:0]  IO_CFG_DEFAULT   = 8'h00;
  localparam logic [7:0]  EN_MODE_DEFAULT  = 8'h00;
  localparam logic [7:0]  ADV_LEN_DEFAULT  = 8'h00;
  localparam logic [7:0]  ADV_DATA_DEFAULT = 8'h00;

  // Recovery sequencer states
  typedef enum {
    ST_LOCK,
    ST_IDLE,
    ST_HOLD,
    ST_ARMED,
    ST_APPLY,
    ST_RESET,
    ST_WAIT_HIGH
  } state_t;

endpackage : recovery_pkg

// *** test/recovery_pin_param_restore_tb.sv ***
`timescale 1ns/1ps
module recovery_pin_param_restore_tb;
  localparam logic [31:0] PREFIX = 32'h4445562d; // Arbitrary name prefix
  localparam logic [15:0] PID    = 16'h5a3c;     // Arbitrary identifier value
  localparam logic [47:0] MAC    = 48'h0123_9a3f_c6e0;
  localparam int          LIMIT  = 70000;

  logic       clk, rst, restore_n, cmd_reset, remote_reset, wr, rd;
  logic [5:0] addr;
  logic [7:0] wdata, rdata;
  logic       pullup_en, sys_reset_req, light_done, deep_done;
  logic       lockout_done, hold_active, light_armed, restore_busy;
  int         errors, total_checks, cycles, pulses, busy_seen;

  // Clock of 4 ns
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // One tick a cycle keeps the whole run short
  recovery_pin_param_restore #(.TICK_CYCLES(1), .NAME_PREFIX(PREFIX), .PRODUCT_ID(PID)) DUT (
    .CLK(clk), .RST(rst), .RESTORE_N(restore_n), .CMD_RESET(cmd_reset),
    .REMOTE_RESET(remote_reset), .HW_ADDR(MAC), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .PULLUP_EN(pullup_en),
    .SYS_RESET_REQ(sys_reset_req), .LIGHT_DONE(light_done), .DEEP_DONE(deep_done),
    .LOCKOUT_DONE(lockout_done), .HOLD_ACTIVE(hold_active), .LIGHT_ARMED(light_armed),
    .RESTORE_BUSY(restore_busy)
  );

  restore_button btn (.clk(clk), .pin_n(restore_n));

  // Cycle count, reset requests, busy cycles and hang limit
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (sys_reset_req === 1'b1) pulses <= pulses + 1;
    if (restore_busy === 1'b1) busy_seen <= busy_seen + 1;
    if (cycles == LIMIT)
    begin
      errors++;
      $display("mismatch timeout expected finish seen hang");
      wrap_up();
    end
  end

  task automatic check_bit(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit

  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check_byte

  task automatic wr_byte(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_byte

  task automatic rd_byte(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_byte

  function automatic logic [7:0] hex_char(input logic [3:0] n);
    return (n < 4'ha) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
  endfunction : hex_char

  // Expected byte after a deep recovery
  function automatic logic [7:0] deep_val(input int i);
    if (i >= 6 && i <= 9) return 8'h01;
    if (i >= 13 && i <= 20) return (i % 2 == 1) ? 8'h35 : 8'h82;
    if (i == 21) return 8'h02;
    if (i == 22) return 8'h1e;
    if (i == 24) return PID[7:0];
    if (i == 25) return PID[15:8];
    if (i >= 45 && i <= 48) return PREFIX[8*(48-i) +: 8];
    if (i >= 49) return hex_char(MAC[4*(56-i) +: 4]);
    return 8'h00;
  endfunction : deep_val

  task automatic fill(input logic [7:0] seed);
    for (int i = 0; i < 57; i++) wr_byte(6'(i), seed ^ 8'(i));
  endtask : fill

  task automatic verify(input logic [7:0] seed, input int last);
    logic [7:0] d;
    for (int i = 0; i < 57; i++)
    begin
      rd_byte(6'(i), d);
      check_byte($sformatf("store byte %0d", i), (i <= last) ? deep_val(i) : seed ^ 8'(i), d);
    end
  endtask : verify

  task automatic wait_pulse(input int lim);
    int n;
    n = 0;
    while (sys_reset_req !== 1'b1 && n < lim)
    begin
      @(posedge clk);
      #1 n++;
    end
    check_bit("reset request", 1'b1, sys_reset_req);
  endtask : wait_pulse

  task automatic test_power_on();
    logic [7:0] d;
    int rel;
    rel = cycles;
    btn.push();
    repeat (6000) @(posedge clk);
    btn.let_go();
    repeat (20) @(posedge clk);
    #1 check_bit("armed in lockout", 1'b0, light_armed);
    check_bit("hold in lockout", 1'b0, hold_active);
    check_bit("request in lockout", 1'b1, pulses == 0);
    wr_byte(6'h3c, 8'hff);
    rd_byte(6'h3c, d);
    check_byte("unmapped read", 8'h00, d);
    while (lockout_done !== 1'b1 && cycles < LIMIT) @(posedge clk);
    check_bit("lockout length", 1'b1, (cycles - rel) inside {[29990:30012]});
    $display("test power_on done");
  endtask : test_power_on

  task automatic test_short_hold();
    btn.push();
    repeat (2000) @(posedge clk);
    #1 check_bit("hold measured", 1'b1, hold_active);
    btn.let_go();
    repeat (20) @(posedge clk);
    #1 check_bit("hold ended", 1'b0, hold_active);
    btn.push();
    repeat (3500) @(posedge clk);
    #1 check_bit("timer restarted", 1'b0, light_armed);
    btn.let_go();
    repeat (20) @(posedge clk);
    #1 check_bit("no action", 1'b1, pulses == 0);
    $display("test short_hold done");
  endtask : test_short_hold

  task automatic test_light();
    logic [7:0] d;
    int b0, p;
    fill(8'ha5);
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clk);
      cmd_reset <= (k == 0);
      remote_reset <= (k == 1);
      @(posedge clk);
      cmd_reset <= 1'b0;
      remote_reset <= 1'b0;
      #1 check_bit("command reset", 1'b1, sys_reset_req);
      check_bit("command light", 1'b0, light_done);
    end
    rd_byte(6'h00, d);
    check_byte("store after command", 8'ha5, d);
    p = pulses;
    btn.push();
    repeat (5012) @(posedge clk);
    #1 check_bit("light armed", 1'b1, light_armed);
    check_bit("held no reset", 1'b1, pulses == p);
    b0 = busy_seen;
    btn.let_go();
    wait_pulse(40);
    check_bit("light done", 1'b1, light_done);
    check_bit("deep not done", 1'b0, deep_done);
    check_bit("light walk length", 1'b1, busy_seen - b0 == 11);
    verify(8'ha5, 10);
    $display("test light done");
  endtask : test_light

  task automatic test_deep();
    int b0, t0;
    fill(8'h5a);
    b0 = busy_seen;
    t0 = cycles;
    btn.push();
    wait_pulse(20200);
    check_bit("deep delay", 1'b1, cycles - t0 >= 19990);
    check_bit("deep done", 1'b1, deep_done);
    check_bit("pin still held", 1'b0, restore_n);
    check_bit("deep walk length", 1'b1, busy_seen - b0 == 57);
    btn.let_go();
    repeat (10) @(posedge clk);
    verify(8'h5a, 56);
    $display("test deep done");
  endtask : test_deep

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  // Reset, then the scenarios in order
  initial
  begin
    {errors, total_checks, cycles, pulses, busy_seen} = '0;
    {rst, cmd_reset, remote_reset, wr, rd} = 5'b10000;
    addr = 6'h00;
    wdata = 8'h00;
    repeat (9) @(posedge clk);
    #1 check_bit("pull-up in reset", 1'b1, pullup_en);
    @(posedge clk);
    rst <= 1'b0;
    test_power_on();
    check_bit("pull-up running", 1'b1, pullup_en);
    test_short_hold();
    test_light();
    test_deep();
    wrap_up();
  end
endmodule : recovery_pin_param_restore_tb

// *** test/restore_button.sv ***
`timescale 1ns/1ps
// Push-button on the recovery pin; an open contact rises through the pull-up
module restore_button (
  input  wire logic clk,
  output logic      pin_n
);
  // Idle high from time zero, so not held low while reset is applied
  initial pin_n = 1'b1;

  // Press: pin pulled low just after an edge
  task automatic push();
    @(posedge clk);
    pin_n <= 1'b0;
  endtask : push

  // Release: pull-up returns the line high
  task automatic let_go();
    @(posedge clk);
    pin_n <= 1'b1;
  endtask : let_go
endmodule : restore_button
